// ### rtl/fpoe_pkg.sv
// Package of constants and carrier types for the flash command sequencer.
package fpoe_pkg;

	// Command codes held in the upper byte of command word 0.
	localparam logic [7:0] CMD_PROG_ONCE   = 8'h07;
	localparam logic [7:0] CMD_ERASE_ALL   = 8'h08;
	localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
	localparam logic [7:0] CMD_ERASE_SECT  = 8'h0A;

	// Last word index required by each command at launch.
	localparam logic [2:0] IDX_PROG_ONCE_LAST = 3'h5;
	localparam logic [2:0] IDX_ERASE_ALL_LAST = 3'h0;
	localparam logic [2:0] IDX_ERASE_LAST     = 3'h1;

	// Word index positions of the parameters.
	localparam logic [2:0] IDX_CMD      = 3'h0;
	localparam logic [2:0] IDX_ADDR     = 3'h1;
	localparam logic [2:0] IDX_DATA0    = 3'h2;

	// Highest valid one-time phrase index and the number of phrases.
	localparam logic [15:0] ONCE_IDX_MAX = 16'h0007;
	localparam int          ONCE_PHRASES = 8;

	// Field positions inside command word 0.
	localparam int CMD_HI_BIT = 15;
	localparam int CMD_LO_BIT = 8;
	localparam int BLK_HI_BIT = 1;
	localparam int BLK_LO_BIT = 0;

	// Operation times as printed and their cycle counts at 100 MHz.
	localparam int  CLK_PERIOD_NS   = 10;
	localparam int  ERASE_TIME_NS   = 1000;
	localparam int  PROG_TIME_NS    = 200;
	localparam int  VERIFY_TIME_NS  = 100;
	localparam int  ERASE_CYCLES    = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int  PROG_CYCLES     = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int  VERIFY_CYCLES   = (VERIFY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int  TIMER_W         = 8;

	// Reset values.
	localparam logic [2:0]  RST_WORD_IDX = 3'h0;
	localparam logic [15:0] RST_WORD     = 16'h0000;

	// Sequencer states, one-hot.
	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_CHECK  = 7'h02,
		ST_BLANK  = 7'h04,
		ST_ERASE  = 7'h08,
		ST_PROG   = 7'h10,
		ST_VERIFY = 7'h20,
		ST_DONE   = 7'h40
	} fpoe_state_e;

	// Status flags as seen by software.
	typedef struct packed {
		logic commandComplete;
		logic accessError;
		logic protectionViolation;
		logic verifyError;
		logic verifyUncorrectable;
	} fpoe_status_s;

	// Request to the flash array core.
	typedef struct packed {
		logic        eraseAll;
		logic        eraseBlock;
		logic        eraseSector;
		logic        programOnce;
		logic        verify;
		logic        blankCheck;
		logic [1:0]  block;
		logic [15:0] addr;
	} fpoe_array_req_s;

	// Answer from the flash array core, valid with verify or blank check.
	typedef struct packed {
		logic anyError;
		logic uncorrectable;
		logic blank;
	} fpoe_array_rsp_s;

endpackage : fpoe_pkg

// ### rtl/fpoe_op_timer.sv
// Down-counter that times one array operation phase.
`timescale 1ns/1ps
module fpoe_op_timer #(
	parameter int WIDTH = 8
) (
	// Clock and reset.
	input  wire logic             mclk,
	input  wire logic             rst,
	// Load and status.
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] count,
	output logic                  expired
);
	import fpoe_pkg::*;

	// Whole state of the timer.
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic             busy;
	} fpoe_timer_s;

	fpoe_timer_s stateReg;   // Registered state.
	fpoe_timer_s stateNext;  // Next state.

	// A load always restarts the count; expiry is a one-cycle pulse.
	always_comb begin
		stateNext = stateReg;
		if (load) begin
			stateNext.cnt  = count;
			stateNext.busy = 1'b1;
		end else if (stateReg.busy) begin
			if (stateReg.cnt <= WIDTH'(1)) begin
				stateNext.busy = 1'b0;
			end
			stateNext.cnt = stateReg.cnt - WIDTH'(1);
		end
	end

	// Register the state.
	always_ff @(posedge mclk) begin
		if (rst) begin
			stateReg <= '0;
		end else begin
			stateReg <= stateNext;
		end
	end

	// Expiry never looks at load: the sequencer derives load from expiry, so a
	// term on load here would close a combinational loop.
	assign expired = stateReg.busy && (stateReg.cnt <= WIDTH'(1));

endmodule : fpoe_op_timer

// ### rtl/fpoe_sequencer.sv
// Command sequencer for one-time program and the three erase commands.
`timescale 1ns/1ps
module fpoe_sequencer #(
	parameter int          ERASE_CYC  = fpoe_pkg::ERASE_CYCLES,
	parameter int          PROG_CYC   = fpoe_pkg::PROG_CYCLES,
	parameter int          VERIFY_CYC = fpoe_pkg::VERIFY_CYCLES,
	parameter logic [3:0]  VALID_BLKS = 4'h3
) (
	// Clock and reset.
	input  wire logic                      mclk,
	input  wire logic                      rst,
	// Software command word access.
	input  wire logic                      wordWrite,
	input  wire logic [2:0]                wordIdxIn,
	input  wire logic [15:0]               wordDataIn,
	input  wire logic                      launch,
	input  wire logic                      errClear,
	// Mode and protection levels from the rest of the device.
	input  wire logic                      cmdAllowed,
	input  wire logic                      anyProtected,
	input  wire logic                      blockProtected,
	input  wire logic                      sectorProtected,
	input  wire logic                      blockIsData,
	input  wire logic [fpoe_pkg::ONCE_PHRASES-1:0] onceProgrammed,
	// Flash array core.
	output fpoe_pkg::fpoe_array_req_s      arrayReq,
	input  wire fpoe_pkg::fpoe_array_rsp_s arrayRsp,
	// Status back to software and device.
	output fpoe_pkg::fpoe_status_s         status,
	output logic [2:0]                     commandWordIndex,
	output logic                           pflashReadInvalid,
	output logic                           securityRelease
);
	import fpoe_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State.

	// All sequencer state in one record.
	typedef struct packed {
		fpoe_state_e     st;
		logic [15:0]     w0;
		logic [15:0]     w1;
		logic [2:0]      idx;
		fpoe_status_s    stat;
		fpoe_array_req_s req;
		logic            rdInvalid;
		logic            secRel;
		logic            verifyIsProg;
	} fpoe_seq_s;

	fpoe_seq_s seqReg;   // Registered state.
	fpoe_seq_s seqNext;  // Next state.

	// Phase timer control.
	logic             timerLoad;   // Restart the phase timer.
	logic [TIMER_W-1:0] timerCount; // Length of the phase.
	logic             timerDone;   // Phase ended this cycle.

	// Decoded command fields.
	logic [7:0] cmdCode;   // Command code in word 0.
	logic [1:0] blockSel;  // Block bits [1:0] in word 0.

	assign cmdCode  = seqReg.w0[CMD_HI_BIT:CMD_LO_BIT];
	assign blockSel = seqReg.w0[BLK_HI_BIT:BLK_LO_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Access error checks for each of the four commands at launch.
	function automatic logic access_fault(
		input logic [7:0]  code,
		input logic [2:0]  idx,
		input logic [15:0] addr,
		input logic [1:0]  blk,
		input logic        allowed,
		input logic        isData,
		input logic [ONCE_PHRASES-1:0] done
	);
		logic f;
		f = !allowed;
		unique case (code)
			CMD_PROG_ONCE: begin
				f = f || (idx != IDX_PROG_ONCE_LAST);
				f = f || (addr > ONCE_IDX_MAX);
				if (addr <= ONCE_IDX_MAX) begin
					f = f || done[addr[2:0]];
				end
			end
			CMD_ERASE_ALL: begin
				f = f || (idx != IDX_ERASE_ALL_LAST);
			end
			CMD_ERASE_BLOCK: begin
				f = f || (idx != IDX_ERASE_LAST);
				f = f || !VALID_BLKS[blk];
				// Data flash needs word alignment, program flash phrase alignment.
				f = f || (isData ? addr[0] : (addr[2:0] != 3'h0));
			end
			CMD_ERASE_SECT: begin
				f = f || (idx != IDX_ERASE_LAST);
				f = f || !VALID_BLKS[blk];
				f = f || (addr[2:0] != 3'h0);
			end
			default: begin
				// Codes outside this block are rejected here.
				f = 1'b1;
			end
		endcase
		return f;
	endfunction : access_fault

	// Protection violation checks for the erase commands.
	function automatic logic protect_fault(
		input logic [7:0] code,
		input logic       anyProt,
		input logic       blkProt,
		input logic       secProt
	);
		logic p;
		p = 1'b0;
		if (code == CMD_ERASE_ALL) begin
			p = anyProt;
		end else if (code == CMD_ERASE_BLOCK) begin
			p = blkProt;
		end else if (code == CMD_ERASE_SECT) begin
			p = secProt;
		end
		return p;
	endfunction : protect_fault

	////////////////////////////////////////////////////////////////////////////////
	// Phase timer.

	fpoe_op_timer #(
		.WIDTH (TIMER_W)
	) u_timer (
		.mclk    (mclk),
		.rst     (rst),
		.load    (timerLoad),
		.count   (timerCount),
		.expired (timerDone)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Words are only accepted while idle; a write during a run is dropped,
	// which shields the running command from a misbehaving host.
	always_comb begin
		seqNext    = seqReg;
		timerLoad  = 1'b0;
		timerCount = '0;
		seqNext.secRel = 1'b0;
		unique case (seqReg.st)
			ST_IDLE: begin
				// Software clears the access and protection error flags while idle.
				if (errClear) begin
					seqNext.stat.accessError         = 1'b0;
					seqNext.stat.protectionViolation = 1'b0;
				end
				if (wordWrite) begin
					seqNext.idx = wordIdxIn;
					if (wordIdxIn == IDX_CMD) begin
						seqNext.w0 = wordDataIn;
					end else if (wordIdxIn == IDX_ADDR) begin
						seqNext.w1 = wordDataIn;
					end
				end
				// Launch is taken only while complete and free of access and protection errors.
				if (launch && seqReg.stat.commandComplete &&
				    !seqReg.stat.accessError && !seqReg.stat.protectionViolation) begin
					seqNext.stat.commandComplete     = 1'b0;
					seqNext.stat.verifyError         = 1'b0;
					seqNext.stat.verifyUncorrectable = 1'b0;
					seqNext.st = ST_CHECK;
				end
			end
			ST_CHECK: begin
				seqNext.req.block = blockSel;
				seqNext.req.addr  = seqReg.w1;
				if (access_fault(cmdCode, seqReg.idx, seqReg.w1, blockSel, cmdAllowed,
				                 blockIsData, onceProgrammed)) begin
					seqNext.stat.accessError = 1'b1;
					seqNext.st = ST_DONE;
				end else if (protect_fault(cmdCode, anyProtected, blockProtected,
				                           sectorProtected)) begin
					seqNext.stat.protectionViolation = 1'b1;
					seqNext.st = ST_DONE;
				end else if (cmdCode == CMD_PROG_ONCE) begin
					// Blank-check the phrase before touching it.
					seqNext.req.blankCheck = 1'b1;
					seqNext.rdInvalid      = 1'b1;
					timerLoad  = 1'b1;
					timerCount = TIMER_W'(VERIFY_CYC);
					seqNext.st = ST_BLANK;
				end else begin
					seqNext.req.eraseAll    = (cmdCode == CMD_ERASE_ALL);
					seqNext.req.eraseBlock  = (cmdCode == CMD_ERASE_BLOCK);
					seqNext.req.eraseSector = (cmdCode == CMD_ERASE_SECT);
					timerLoad  = 1'b1;
					timerCount = TIMER_W'(ERASE_CYC);
					seqNext.st = ST_ERASE;
				end
			end
			ST_BLANK: begin
				if (timerDone) begin
					seqNext.req.blankCheck = 1'b0;
					if (arrayRsp.blank) begin
						seqNext.req.programOnce = 1'b1;
						timerLoad  = 1'b1;
						timerCount = TIMER_W'(PROG_CYC);
						seqNext.st = ST_PROG;
					end else begin
						// Phrase holds data already; it can never be erased.
						seqNext.stat.accessError = 1'b1;
						seqNext.rdInvalid = 1'b0;
						seqNext.st = ST_DONE;
					end
				end
			end
			ST_PROG: begin
				if (timerDone) begin
					seqNext.req.programOnce = 1'b0;
					seqNext.req.verify      = 1'b1;
					seqNext.verifyIsProg    = 1'b1;
					timerLoad  = 1'b1;
					timerCount = TIMER_W'(VERIFY_CYC);
					seqNext.st = ST_VERIFY;
				end
			end
			ST_ERASE: begin
				if (timerDone) begin
					seqNext.req.verify   = 1'b1;
					seqNext.verifyIsProg = 1'b0;
					timerLoad  = 1'b1;
					timerCount = TIMER_W'(VERIFY_CYC);
					seqNext.st = ST_VERIFY;
				end
			end
			ST_VERIFY: begin
				if (timerDone) begin
					seqNext.stat.verifyError         = arrayRsp.anyError;
					seqNext.stat.verifyUncorrectable = arrayRsp.uncorrectable;
					// Erase-all that verifies clean lifts security.
					seqNext.secRel = seqReg.req.eraseAll && !arrayRsp.anyError;
					seqNext.req       = '0;
					seqNext.rdInvalid = 1'b0;
					seqNext.st = ST_DONE;
				end
			end
			ST_DONE: begin
				// Complete is raised only here, after every phase is over.
				seqNext.stat.commandComplete = 1'b1;
				seqNext.req = '0;
				seqNext.st  = ST_IDLE;
			end
			default: begin
				seqNext.st = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	// Reset leaves the controller idle and ready with complete set.
	always_ff @(posedge mclk) begin
		if (rst) begin
			seqReg                      <= '0;
			seqReg.st                   <= ST_IDLE;
			seqReg.idx                  <= RST_WORD_IDX;
			seqReg.w0                   <= RST_WORD;
			seqReg.w1                   <= RST_WORD;
			seqReg.stat.commandComplete <= 1'b1;
		end else begin
			seqReg <= seqNext;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs, all straight from flip-flops.

	assign status            = seqReg.stat;
	assign arrayReq          = seqReg.req;
	assign commandWordIndex  = seqReg.idx;
	assign pflashReadInvalid = seqReg.rdInvalid;
	assign securityRelease   = seqReg.secRel;

endmodule : fpoe_sequencer

// ### test/fpoe_sequencer_props.sv
// Checker of the flash command sequencer's port behaviour.
`timescale 1ns/1ps
module fpoe_sequencer_props
	import fpoe_pkg::*;
(
	// Clock and reset.
	input wire logic            mclk,
	input wire logic            rst,
	// Software side.
	input wire logic            wordWrite,
	input wire logic [2:0]      wordIdxIn,
	input wire logic [15:0]     wordDataIn,
	input wire logic            launch,
	input wire logic            cmdAllowed,
	input wire logic            anyProtected,
	// Array and status.
	input wire fpoe_array_req_s arrayReq,
	input wire fpoe_array_rsp_s arrayRsp,
	input wire fpoe_status_s    status,
	input wire logic [2:0]      commandWordIndex,
	input wire logic            pflashReadInvalid,
	input wire logic            securityRelease
);

	////////////////////////////////////////////////////////////////////////////////
	// The code in slot 0 is only accepted while idle, so shadow it the same way.
	logic [7:0] codeReg;
	logic       launchOk;
	always_ff @(posedge mclk) begin
		if (rst) begin
			codeReg <= 8'h00;
		end else if (wordWrite && status.commandComplete && wordIdxIn == IDX_CMD) begin
			codeReg <= wordDataIn[15:8];
		end
	end
	// A launch is taken only when idle with no access or protection flag.
	assign launchOk = launch && status.commandComplete && !status.accessError &&
		!status.protectionViolation;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////
	property p_launch_clears;
		launchOk |=> !status.commandComplete;
	endproperty
	a_launch_clears: assert property (p_launch_clears)
		else $error("complete flag not cleared by launch");

	property p_refused;
		launch && status.commandComplete && status.accessError |=> status.commandComplete;
	endproperty
	a_refused: assert property (p_refused)
		else $error("launch taken while access error stands");

	property p_mode;
		launchOk ##1 !cmdAllowed |-> ##[1:3] (status.commandComplete && status.accessError);
	endproperty
	a_mode: assert property (p_mode)
		else $error("disallowed command did not end with access error");

	property p_prot_all;
		launchOk && codeReg == CMD_ERASE_ALL && commandWordIndex == IDX_ERASE_ALL_LAST
			##1 (anyProtected && cmdAllowed)
			|-> ##[1:3] (status.commandComplete && status.protectionViolation);
	endproperty
	a_prot_all: assert property (p_prot_all)
		else $error("protected erase-all did not end with violation");

	property p_busy;
		(arrayReq.eraseAll || arrayReq.eraseBlock || arrayReq.eraseSector ||
			arrayReq.programOnce) |-> !status.commandComplete;
	endproperty
	a_busy: assert property (p_busy)
		else $error("complete flag high during array operation");

	property p_rdinv;
		arrayReq.programOnce |-> pflashReadInvalid;
	endproperty
	a_rdinv: assert property (p_rdinv)
		else $error("reads not invalidated during one-time program");

	property p_sec;
		securityRelease |-> !status.verifyError && codeReg == CMD_ERASE_ALL
			##1 !securityRelease ##[0:1] status.commandComplete;
	endproperty
	a_sec: assert property (p_sec)
		else $error("security released without clean erase-all");

	property p_verify;
		$fell(arrayReq.verify) && !arrayReq.programOnce && !arrayReq.blankCheck |->
			status.verifyError == $past(arrayRsp.anyError) &&
			status.verifyUncorrectable == $past(arrayRsp.uncorrectable);
	endproperty
	a_verify: assert property (p_verify)
		else $error("verify flags do not follow the array answer");

	property p_index;
		wordWrite && status.commandComplete |=> commandWordIndex == $past(wordIdxIn);
	endproperty
	a_index: assert property (p_index)
		else $error("word index not updated by idle write");

endmodule : fpoe_sequencer_props

bind fpoe_sequencer fpoe_sequencer_props u_props (
	.mclk(mclk), .rst(rst), .wordWrite(wordWrite), .wordIdxIn(wordIdxIn),
	.wordDataIn(wordDataIn), .launch(launch), .cmdAllowed(cmdAllowed),
	.anyProtected(anyProtected), .arrayReq(arrayReq), .arrayRsp(arrayRsp),
	.status(status), .commandWordIndex(commandWordIndex),
	.pflashReadInvalid(pflashReadInvalid), .securityRelease(securityRelease)
);

// ### test/fpoe_sequencer_test.sv
// Self-checking bench for the flash command sequencer.
`timescale 1ns/1ps
module fpoe_sequencer_test;
	import fpoe_pkg::*;

	// Short phase counts keep the run brief; the timer is only 8 bits wide.
	localparam int EC = 8;
	localparam int PC = 4;
	localparam int VC = 3;

	logic            mclk;
	logic            rst;
	logic            wordWrite;
	logic [2:0]      wordIdxIn;
	logic [15:0]     wordDataIn;
	logic            launch;
	logic            errClear;
	logic            cmdAllowed;
	logic            anyProtected;
	logic            blockProtected;
	logic            sectorProtected;
	logic            blockIsData;
	logic [7:0]      onceProgrammed;
	fpoe_array_req_s arrayReq;
	fpoe_array_rsp_s arrayRsp;
	fpoe_status_s    status;
	logic [2:0]      commandWordIndex;
	logic            pflashReadInvalid;
	logic            securityRelease;
	int              errCount;
	int              checksDone;

	fpoe_sequencer #(.ERASE_CYC(EC), .PROG_CYC(PC), .VERIFY_CYC(VC)) u_dut (
		.mclk(mclk), .rst(rst), .wordWrite(wordWrite), .wordIdxIn(wordIdxIn),
		.wordDataIn(wordDataIn), .launch(launch), .errClear(errClear),
		.cmdAllowed(cmdAllowed), .anyProtected(anyProtected),
		.blockProtected(blockProtected), .sectorProtected(sectorProtected),
		.blockIsData(blockIsData), .onceProgrammed(onceProgrammed),
		.arrayReq(arrayReq), .arrayRsp(arrayRsp), .status(status),
		.commandWordIndex(commandWordIndex), .pflashReadInvalid(pflashReadInvalid),
		.securityRelease(securityRelease)
	);

	// Free-running 100 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", checksDone, errCount);
		if (errCount == 0 && checksDone > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	// Four-state compare, so an unknown never passes.
	task automatic chk(input logic [4:0] got, input logic [4:0] exp);
		checksDone++;
		if (got !== exp) begin
			errCount++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	// Inputs always change 1 ns after the rising edge.
	task automatic step;
		@(posedge mclk);
		#1;
	endtask : step

	// One-cycle write of a command word slot; the strobe stays high across
	// back-to-back writes and the caller lowers it after the last one.
	task automatic wr(input logic [2:0] i, input logic [15:0] d);
		wordIdxIn = i;
		wordDataIn = d;
		wordWrite = 1'b1;
		step();
	endtask : wr

	// Loads slots 0..last, launches, waits for completion and checks flags,
	// array activity and the security pulse. Env is {allowed, anyProt,
	// blkProt, secProt, isData}; expFlags is {access, prot, verify, uncorr}.
	task automatic run(input logic [7:0] code, input logic [1:0] blk,
			input logic [15:0] addr, input logic [2:0] last, input logic [4:0] env,
			input logic [2:0] rsp, input logic [3:0] expFlags,
			input logic [3:0] expReq, input logic expSec);
		int         n;
		logic [3:0] req;
		logic       sec;
		logic       rdInv;
		logic       vfy;
		logic       tgtOk;
		req = 4'h0;
		sec = 1'b0;
		rdInv = 1'b0;
		vfy = 1'b0;
		tgtOk = 1'b1;
		{cmdAllowed, anyProtected, blockProtected, sectorProtected, blockIsData} = env;
		arrayRsp = rsp;
		wr(3'h0, {code, 6'h00, blk});
		for (int i = 1; i <= last; i++) begin
			wr(i[2:0], (i == 1) ? addr : {8'hA5, 5'h00, i[2:0]});
		end
		wordWrite = 1'b0;
		launch = 1'b1;
		step();
		launch = 1'b0;
		chk({4'h0, status.commandComplete}, 5'h00);
		n = 0;
		// Bounded wait; the array request bits are collected on the way.
		// Nothing is written to the block until complete returns.
		while (status.commandComplete !== 1'b1 && n < 400) begin
			req |= {arrayReq.eraseAll, arrayReq.eraseBlock, arrayReq.eraseSector,
				arrayReq.programOnce};
			sec |= securityRelease;
			rdInv |= pflashReadInvalid;
			vfy |= arrayReq.verify;
			// Block and address must reach the array with every targeted operation.
			if ((arrayReq.eraseBlock || arrayReq.eraseSector || arrayReq.programOnce) &&
				({arrayReq.block, arrayReq.addr} !== {blk, addr})) begin
				tgtOk = 1'b0;
			end
			step();
			n++;
		end
		if (n >= 400) begin
			errCount++;
			close_out();
		end
		chk(status, {1'b1, expFlags});
		chk({1'b0, req}, {1'b0, expReq});
		chk({3'h0, sec, rdInv | ~expReq[0]}, {3'h0, expSec, 1'b1});
		chk({3'h0, vfy, tgtOk}, {3'h0, (expReq != 4'h0), 1'b1});
		// A standing access or protection flag must refuse a new launch.
		if (expFlags[3:2] != 2'b00) begin
			launch = 1'b1;
			step();
			launch = 1'b0;
			chk({4'h0, status.commandComplete}, 5'h01);
		end
		errClear = 1'b1;
		step();
		errClear = 1'b0;
		chk(status, {3'b100, expFlags[1:0]});
	endtask : run

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		errCount = 0;
		checksDone = 0;
		rst = 1'b1;
		{wordWrite, launch, errClear} = 3'h0;
		wordIdxIn = 3'h0;
		wordDataIn = 16'h0000;
		{cmdAllowed, anyProtected, blockProtected, sectorProtected, blockIsData} = 5'h10;
		onceProgrammed = 8'h00;
		arrayRsp = 3'h1;
		repeat (16) @(posedge mclk);
		#1;
		rst = 1'b0;
		chk(status, 5'h10);
		run(CMD_ERASE_ALL, 2'h0, 16'h0000, 3'h0, 5'h10, 3'h1, 4'h0, 4'h8, 1'b1);
		run(CMD_ERASE_ALL, 2'h0, 16'h0000, 3'h0, 5'h10, 3'h6, 4'h3, 4'h8, 1'b0);
		run(CMD_ERASE_ALL, 2'h0, 16'h0000, 3'h0, 5'h18, 3'h1, 4'h4, 4'h0, 1'b0);
		run(CMD_ERASE_ALL, 2'h0, 16'h0000, 3'h1, 5'h10, 3'h1, 4'h8, 4'h0, 1'b0);
		run(CMD_ERASE_ALL, 2'h0, 16'h0000, 3'h0, 5'h00, 3'h1, 4'h8, 4'h0, 1'b0);
		run(CMD_ERASE_BLOCK, 2'h1, 16'h0010, 3'h1, 5'h10, 3'h1, 4'h0, 4'h4, 1'b0);
		run(CMD_ERASE_BLOCK, 2'h2, 16'h0010, 3'h1, 5'h10, 3'h1, 4'h8, 4'h0, 1'b0);
		run(CMD_ERASE_BLOCK, 2'h0, 16'h0004, 3'h1, 5'h10, 3'h1, 4'h8, 4'h0, 1'b0);
		run(CMD_ERASE_BLOCK, 2'h0, 16'h0001, 3'h1, 5'h11, 3'h1, 4'h8, 4'h0, 1'b0);
		run(CMD_ERASE_BLOCK, 2'h0, 16'h0002, 3'h1, 5'h11, 3'h1, 4'h0, 4'h4, 1'b0);
		run(CMD_ERASE_BLOCK, 2'h0, 16'h0000, 3'h1, 5'h14, 3'h1, 4'h4, 4'h0, 1'b0);
		run(CMD_ERASE_BLOCK, 2'h0, 16'h0000, 3'h0, 5'h10, 3'h1, 4'h8, 4'h0, 1'b0);
		run(CMD_ERASE_SECT, 2'h0, 16'h0208, 3'h1, 5'h10, 3'h1, 4'h0, 4'h2, 1'b0);
		run(CMD_ERASE_SECT, 2'h0, 16'h0203, 3'h1, 5'h10, 3'h1, 4'h8, 4'h0, 1'b0);
		run(CMD_ERASE_SECT, 2'h0, 16'h0208, 3'h1, 5'h12, 3'h1, 4'h4, 4'h0, 1'b0);
		run(CMD_ERASE_SECT, 2'h3, 16'h0208, 3'h1, 5'h10, 3'h1, 4'h8, 4'h0, 1'b0);
		run(CMD_ERASE_SECT, 2'h0, 16'h0208, 3'h1, 5'h00, 3'h1, 4'h8, 4'h0, 1'b0);
		run(CMD_PROG_ONCE, 2'h0, 16'h0003, 3'h5, 5'h10, 3'h1, 4'h0, 4'h1, 1'b0);
		run(CMD_PROG_ONCE, 2'h0, 16'h0008, 3'h5, 5'h10, 3'h1, 4'h8, 4'h0, 1'b0);
		run(CMD_PROG_ONCE, 2'h0, 16'h0007, 3'h5, 5'h10, 3'h0, 4'h8, 4'h0, 1'b0);
		run(CMD_PROG_ONCE, 2'h0, 16'h0003, 3'h4, 5'h10, 3'h1, 4'h8, 4'h0, 1'b0);
		run(CMD_PROG_ONCE, 2'h0, 16'h0003, 3'h5, 5'h00, 3'h1, 4'h8, 4'h0, 1'b0);
		// Phrase 3 now holds data and is never programmed again; phrase 5 is
		// marked programmed to show the refusal.
		onceProgrammed = 8'h28;
		run(CMD_PROG_ONCE, 2'h0, 16'h0005, 3'h5, 5'h10, 3'h1, 4'h8, 4'h0, 1'b0);
		close_out();
	end

endmodule : fpoe_sequencer_test
